//--- pkg/tcc_pkg.sv
// Constants shared by the timer capture/compare block
`default_nettype none

package tcc_pkg;

  localparam int ADDR_W = 6;

  // Register byte addresses, one byte per aligned word
  localparam logic [5:0] ADDR_MAIN    = 6'h00;
  localparam logic [5:0] ADDR_CNT_HI  = 6'h04;
  localparam logic [5:0] ADDR_CNT_LO  = 6'h08;
  localparam logic [5:0] ADDR_MOD_HI  = 6'h0c;
  localparam logic [5:0] ADDR_MOD_LO  = 6'h10;
  localparam logic [5:0] ADDR_CH_CTL  = 6'h14;
  localparam logic [5:0] ADDR_CH_HI   = 6'h18;
  localparam logic [5:0] ADDR_CH_LO   = 6'h1c;
  localparam logic [5:0] ADDR_CH_STEP = 6'h0c;

  // timer_main_control fields
  localparam int MAIN_WRAP = 7;
  localparam int MAIN_HALT = 5;
  localparam int MAIN_CRST = 4;
  localparam int MAIN_DIV  = 0;

  // Channel control/status fields
  localparam int CH_FLAG = 7;
  localparam int CH_IE   = 6;
  localparam int CH_BUF  = 5;
  localparam int CH_UNB  = 4;
  localparam int CH_ELH  = 3;
  localparam int CH_ELL  = 2;
  localparam int CH_TOV  = 1;
  localparam int CH_MAX  = 0;

  // Reset values and codes
  localparam logic [15:0] MOD_RST   = 16'hffff;
  localparam logic [6:0]  CTL_RST   = 7'h00;
  localparam logic [2:0]  DIV_RST   = 3'h0;
  localparam logic [2:0]  DIV_EXT   = 3'h7;
  localparam logic [1:0]  EL_TOGGLE = 2'h1;
  localparam logic [1:0]  EL_LOW    = 2'h2;
  localparam logic [1:0]  EL_HIGH   = 2'h3;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;

endpackage : tcc_pkg

`default_nettype wire

//--- core/tcc_top.sv
// Timer with modulo counter and two capture/compare channels, AXI4-Lite slave
// Operation
// RL1: Counter upper-byte read latches lower byte until lower byte read releases it.
// RL2: System reset or counter reset bit clears the counter to zero.
// RL3: Counter equal to modulo sets wrap flag and restarts from zero.
// RL4: Modulo upper-byte write suppresses wrap flag until lower byte written.
// RL5: Reset sets modulo to all ones, full sixteen-bit range.
// RL6: Software should reset the counter before writing new modulo values.
// RL7: Channel flag sets on active capture edge or on compare match.
// RL8: Flag clears by read-while-set then write zero; new event wins.
// RL9: Per-channel interrupt enable gates flag onto interrupt request; reset clears.
// RL10: Channel zero buffered bit disables channel one control and pin.
// RL11: Unbuffered bit picks compare or capture; with edge field zero, preset level.
// RL12: Edge field zero disconnects channel from its pin; reset clears.
// RL13: Capture edges: 01 rising, 10 falling, 11 either.
// RL14: Compare action: 00 none, 01 toggle, 10 low, 11 high.
// RL15: Wrap toggle bit toggles compare pin at each overflow.
// RL16: Overflow toggle takes priority over a coincident compare action.
// RL17: Full duty bit with wrap toggle forces 100% duty from next period.
// RL18: Channel values hold capture or compare values; undefined after reset.
// RL19: Capture mode upper-byte read blocks captures until lower byte read.
// RL20: Compare mode upper-byte write blocks matches until lower byte written.
// RL21: Software should halt and reset counter before changing channel mode.
// RL22: Software should clear channel flag after enabling capture.
// RL23: Halt bit stops counting while set; reset sets it.
// RL24: Counter reset bit clears counter and prescaler, self-clears, reads zero.
// RL25: Divider select picks bus clock divide 1 to 64, or external clock.
// RL26: Buffered bit links channels; channel zero values act first on pin zero.
// RL27: Buffered compare source alternates between channel values at each overflow.
// RL28: Counter, modulo and channel values are sixteen bits in two bytes.
//
// Local design decisions: the AXI4-Lite register port and the address map.
`default_nettype none

module tcc_top
  import tcc_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RESET,
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY,
  input  wire logic              EXT_TIMER_CLK,
  input  wire logic [1:0]        CH_PIN_IN,
  output logic      [1:0]        CH_PIN_OUT,
  output logic      [1:0]        CH_PIN_OE,
  output logic      [1:0]        CHAN_IRQ
);

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] c;
    c = a - ADDR_CH_CTL;
    is_mapped = (a <= ADDR_MOD_LO || (a >= ADDR_CH_CTL && c < 6'(2) * ADDR_CH_STEP))
                && (a[1:0] == 2'h0);
  endfunction : is_mapped

  // Bus slave state
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0]        wdata_reg;
  logic              wstrb_reg;
  logic              aw_have_reg;
  logic              w_have_reg;

  wire wr_go = aw_have_reg && w_have_reg && !BVALID;
  wire wr_en = wr_go && wstrb_reg && is_mapped(awaddr_reg);
  wire rd_go = ARVALID && ARREADY;

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      AWREADY     <= 1'b1;
      WREADY      <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= 8'h00;
      wstrb_reg   <= 1'b0;
      BVALID      <= 1'b0;
      BRESP       <= RESP_OKAY;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        awaddr_reg  <= AWADDR;
        aw_have_reg <= 1'b1;
        AWREADY     <= 1'b0;
      end
      if (WVALID && WREADY)
      begin
        wdata_reg  <= WDATA[7:0];
        wstrb_reg  <= WSTRB[0];
        w_have_reg <= 1'b1;
        WREADY     <= 1'b0;
      end
      if (wr_go)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        BVALID      <= 1'b1;
        BRESP       <= is_mapped(awaddr_reg) ? RESP_OKAY : RESP_ERR;
      end
      if (BVALID && BREADY)
      begin
        BVALID  <= 1'b0;
        AWREADY <= 1'b1;
        WREADY  <= 1'b1;
      end
    end
  end

  wire wr_main   = wr_en && awaddr_reg == ADDR_MAIN;
  wire wr_mod_hi = wr_en && awaddr_reg == ADDR_MOD_HI;
  wire wr_mod_lo = wr_en && awaddr_reg == ADDR_MOD_LO;
  wire rd_main   = rd_go && ARADDR == ADDR_MAIN;
  wire rd_cnt_hi = rd_go && ARADDR == ADDR_CNT_HI;
  wire rd_cnt_lo = rd_go && ARADDR == ADDR_CNT_LO;

  // Main control, prescaler and counter
  logic        halt_reg;
  logic [2:0]  div_reg;
  logic        wrap_flag_reg;
  logic        wrap_arm_reg;
  logic [5:0]  pre_reg;
  logic [15:0] cnt_reg;
  logic [15:0] mod_reg;
  logic        mod_pend_reg;
  logic        cnt_lat_reg;
  logic [7:0]  cnt_hold_reg;
  logic [2:0]  ext_sync_reg;

  wire       cnt_rst  = wr_main && wdata_reg[MAIN_CRST];
  wire [5:0] pre_mask = 6'(7'h7f >> (3'h7 - div_reg));
  wire       ext_rise = ext_sync_reg[1] && !ext_sync_reg[2];
  wire       pre_hit  = (div_reg == DIV_EXT) ? ext_rise : ((pre_reg & pre_mask) == pre_mask);
  wire       tick     = !halt_reg && !cnt_rst && pre_hit; // RL23 RL25
  wire       ovf      = tick && (cnt_reg == mod_reg);
  wire       wrap_set = ovf && !mod_pend_reg; // RL4
  wire       wrap_clr = wr_main && !wdata_reg[MAIN_WRAP] && wrap_arm_reg;

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      halt_reg      <= 1'b1; // RL23
      div_reg       <= DIV_RST;
      wrap_flag_reg <= 1'b0;
      wrap_arm_reg  <= 1'b0;
      pre_reg       <= 6'h00;
      cnt_reg       <= 16'h0000;
      mod_reg       <= MOD_RST; // RL5
      mod_pend_reg  <= 1'b0;
      ext_sync_reg  <= 3'h0;
    end
    else
    begin
      ext_sync_reg <= {ext_sync_reg[1:0], EXT_TIMER_CLK};
      if (wr_main)
      begin
        halt_reg <= wdata_reg[MAIN_HALT];
        div_reg  <= wdata_reg[MAIN_DIV +: 3];
      end
      if (cnt_rst)
      begin
        pre_reg <= 6'h00; // RL24
        cnt_reg <= 16'h0000; // RL2
      end
      else
      begin
        if (!halt_reg)
          pre_reg <= pre_reg + 6'h01;
        if (tick)
          cnt_reg <= ovf ? 16'h0000 : cnt_reg + 16'h0001; // RL3
      end
      if (wrap_set)
        wrap_flag_reg <= 1'b1; // RL3
      else if (wrap_clr)
        wrap_flag_reg <= 1'b0;
      if (wrap_set || wr_main)
        wrap_arm_reg <= 1'b0;
      else if (rd_main && wrap_flag_reg)
        wrap_arm_reg <= 1'b1;
      if (wr_mod_hi)
      begin
        mod_reg[15:8] <= wdata_reg;
        mod_pend_reg  <= 1'b1; // RL4
      end
      if (wr_mod_lo)
      begin
        mod_reg[7:0] <= wdata_reg; // RL28
        mod_pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      cnt_lat_reg  <= 1'b0;
      cnt_hold_reg <= 8'h00;
    end
    else if (rd_cnt_hi && !cnt_lat_reg)
    begin
      cnt_lat_reg  <= 1'b1; // RL1
      cnt_hold_reg <= cnt_reg[7:0];
    end
    else if (rd_cnt_lo)
      cnt_lat_reg <= 1'b0; // RL1
  end

  // Channels
  logic [6:0]  ctl_reg   [2];
  logic [15:0] val_reg   [2];
  logic [1:0]  flag_reg;
  logic [1:0]  arm_reg;
  logic [1:0]  cap_blk_reg;
  logic [1:0]  cmp_blk_reg;
  logic [1:0]  max_eff_reg;
  logic [1:0]  ch_sync1_reg;
  logic [1:0]  ch_sync2_reg;
  logic [1:0]  ch_sync3_reg;
  logic        bsel_reg;
  logic [1:0]  cap_ev;
  logic [1:0]  match;
  logic [1:0]  rd_ctl;
  logic [1:0]  rd_hi;
  logic [1:0]  rd_lo;
  logic [1:0]  cmp_mode;
  logic [1:0]  cap_mode;
  logic [7:0]  ctl_rd [2];

  wire buf_on = ctl_reg[0][CH_BUF]; // RL26

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      bsel_reg <= 1'b0;
    else if (!buf_on)
      bsel_reg <= 1'b0; // RL26
    else if (ovf)
      bsel_reg <= !bsel_reg; // RL27
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      ch_sync1_reg <= 2'h0;
      ch_sync2_reg <= 2'h0;
      ch_sync3_reg <= 2'h0;
    end
    else
    begin
      ch_sync1_reg <= CH_PIN_IN;
      ch_sync2_reg <= ch_sync1_reg;
      ch_sync3_reg <= ch_sync2_reg;
    end
  end

  for (genvar i = 0; i < 2; i++)
  begin : g_ch
    localparam logic [5:0] A_CTL = ADDR_CH_CTL + 6'(i) * ADDR_CH_STEP;
    localparam logic [5:0] A_HI  = ADDR_CH_HI + 6'(i) * ADDR_CH_STEP;
    localparam logic [5:0] A_LO  = ADDR_CH_LO + 6'(i) * ADDR_CH_STEP;

    // Second channel goes dark while the pair is linked
    wire        off   = (i == 1) && buf_on; // RL10
    wire        lead  = (i == 0) && buf_on;
    wire [6:0]  c     = off ? 7'h00 : ctl_reg[i];
    wire [1:0]  els   = c[CH_ELH:CH_ELL];
    wire        conn  = els != 2'h0; // RL12
    wire [15:0] cv    = lead ? val_reg[bsel_reg] : val_reg[i]; // RL27
    wire        blk   = lead ? cmp_blk_reg[bsel_reg] : cmp_blk_reg[i];
    wire        rise  = ch_sync2_reg[i] && !ch_sync3_reg[i];
    wire        fall  = !ch_sync2_reg[i] && ch_sync3_reg[i];
    wire        wr_c  = wr_en && awaddr_reg == A_CTL;
    wire        wr_h  = wr_en && awaddr_reg == A_HI;
    wire        wr_l  = wr_en && awaddr_reg == A_LO;
    wire        ev    = cap_ev[i] || match[i];
    wire        tov   = cmp_mode[i] && c[CH_TOV];
    wire [6:0]  wmask = (i == 0) ? 7'h7f : 7'h5f;

    assign cmp_mode[i] = c[CH_UNB] || lead; // RL11
    assign cap_mode[i] = conn && !cmp_mode[i]; // RL11
    assign cap_ev[i]   = cap_mode[i] && !halt_reg && !cap_blk_reg[i]
                         && ((els[0] && rise) || (els[1] && fall)); // RL13 RL19
    assign match[i]    = cmp_mode[i] && tick && cnt_reg == cv && !blk; // RL7 RL20
    assign rd_ctl[i]   = rd_go && ARADDR == A_CTL;
    assign rd_hi[i]    = rd_go && ARADDR == A_HI;
    assign rd_lo[i]    = rd_go && ARADDR == A_LO;
    assign ctl_rd[i]   = {flag_reg[i], ctl_reg[i]};

    // Values carry no reset; software loads them before use
    always_ff @(posedge CLK)
    begin
      if (cap_ev[i])
        val_reg[i] <= cnt_reg; // RL18
      else if (wr_h)
        val_reg[i][15:8] <= wdata_reg;
      else if (wr_l)
        val_reg[i][7:0] <= wdata_reg;
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
      if (RESET)
      begin
        ctl_reg[i]     <= CTL_RST;
        flag_reg[i]    <= 1'b0;
        arm_reg[i]     <= 1'b0;
        cap_blk_reg[i] <= 1'b0;
        cmp_blk_reg[i] <= 1'b0;
      end
      else
      begin
        if (wr_c && !off)
          ctl_reg[i] <= wdata_reg[6:0] & wmask; // RL10
        if (ev)
          flag_reg[i] <= 1'b1; // RL7
        else if (wr_c && !off && !wdata_reg[CH_FLAG] && arm_reg[i])
          flag_reg[i] <= 1'b0; // RL8
        if (ev || wr_c)
          arm_reg[i] <= 1'b0; // RL8
        else if (rd_ctl[i] && flag_reg[i])
          arm_reg[i] <= 1'b1;
        if (rd_hi[i] && cap_mode[i])
          cap_blk_reg[i] <= 1'b1; // RL19
        else if (rd_lo[i])
          cap_blk_reg[i] <= 1'b0;
        if (wr_h && (cmp_mode[i] || buf_on))
          cmp_blk_reg[i] <= 1'b1; // RL20
        else if (wr_l)
          cmp_blk_reg[i] <= 1'b0;
      end
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
      if (RESET)
      begin
        CH_PIN_OUT[i]  <= 1'b1;
        CH_PIN_OE[i]   <= 1'b0;
        CHAN_IRQ[i]    <= 1'b0;
        max_eff_reg[i] <= 1'b0;
      end
      else
      begin
        // Capture pins stay inputs; only compare/PWM drives the pin
        CH_PIN_OE[i] <= conn && cmp_mode[i]; // RL12
        CHAN_IRQ[i]  <= flag_reg[i] && ctl_reg[i][CH_IE]; // RL9
        if (ovf || !tov)
          max_eff_reg[i] <= c[CH_MAX]; // RL17
        if (!conn)
          CH_PIN_OUT[i] <= !c[CH_UNB]; // RL11
        else if (tov && max_eff_reg[i])
          CH_PIN_OUT[i] <= 1'b1; // RL17
        else if (tov && ovf)
          CH_PIN_OUT[i] <= !CH_PIN_OUT[i]; // RL15 RL16
        else if (cmp_mode[i] && match[i])
        begin
          if (els == EL_TOGGLE)
            CH_PIN_OUT[i] <= !CH_PIN_OUT[i]; // RL14
          else if (els == EL_LOW)
            CH_PIN_OUT[i] <= 1'b0;
          else if (els == EL_HIGH)
            CH_PIN_OUT[i] <= 1'b1;
        end
      end
    end
  end

  // Read data selection
  wire [7:0] main_rd = {wrap_flag_reg, 1'b0, halt_reg, 2'b00, div_reg};
  wire [7:0] rd_byte =
    (ARADDR == ADDR_MAIN)   ? main_rd :
    (ARADDR == ADDR_CNT_HI) ? cnt_reg[15:8] :
    (ARADDR == ADDR_CNT_LO) ? (cnt_lat_reg ? cnt_hold_reg : cnt_reg[7:0]) :
    (ARADDR == ADDR_MOD_HI) ? mod_reg[15:8] :
    (ARADDR == ADDR_MOD_LO) ? mod_reg[7:0] :
    rd_ctl[0]               ? ctl_rd[0] :
    rd_hi[0]                ? val_reg[0][15:8] :
    rd_lo[0]                ? val_reg[0][7:0] :
    rd_ctl[1]               ? ctl_rd[1] :
    rd_hi[1]                ? val_reg[1][15:8] :
    rd_lo[1]                ? val_reg[1][7:0] : 8'h00;

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      ARREADY <= 1'b1;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0000_0000;
      RRESP   <= RESP_OKAY;
    end
    else if (rd_go)
    begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b1;
      RDATA   <= is_mapped(ARADDR) ? {24'h000000, rd_byte} : 32'h0000_0000;
      RRESP   <= is_mapped(ARADDR) ? RESP_OKAY : RESP_ERR;
    end
    else if (RVALID && RREADY)
    begin
      RVALID  <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // Checks
  property p_cnt_clear;
    @(posedge CLK) disable iff (RESET)
    cnt_rst |=> cnt_reg == 16'h0000 && pre_reg == 6'h00;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("counter not cleared"); // RL2

  property p_wrap;
    @(posedge CLK) disable iff (RESET)
    wrap_set |=> wrap_flag_reg && cnt_reg == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag or restart missed"); // RL3

  property p_mod_inhibit;
    @(posedge CLK) disable iff (RESET)
    $rose(wrap_flag_reg) |-> !$past(mod_pend_reg);
  endproperty
  a_mod_inhibit: assert property (p_mod_inhibit) else $error("wrap during modulo update"); // RL4

  property p_halt;
    @(posedge CLK) disable iff (RESET)
    halt_reg && !cnt_rst |=> $stable(cnt_reg);
  endproperty
  a_halt: assert property (p_halt) else $error("counter moved while halted"); // RL23

  property p_latch;
    @(posedge CLK) disable iff (RESET)
    cnt_lat_reg && !rd_cnt_lo |=> cnt_lat_reg && $stable(cnt_hold_reg);
  endproperty
  a_latch: assert property (p_latch) else $error("held low byte disturbed"); // RL1

  property p_flag_cause;
    @(posedge CLK) disable iff (RESET)
    $rose(flag_reg[0]) |-> $past(cap_ev[0] || match[0]);
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flag set without event"); // RL7

  property p_irq;
    @(posedge CLK) disable iff (RESET)
    flag_reg[1] && ctl_reg[1][CH_IE] |=> CHAN_IRQ[1];
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request missing"); // RL9

  property p_disconnect;
    @(posedge CLK) disable iff (RESET)
    ctl_reg[0][CH_ELH:CH_ELL] == 2'h0 |=> !CH_PIN_OE[0];
  endproperty
  a_disconnect: assert property (p_disconnect) else $error("pin driven while off"); // RL12

  property p_cap_block;
    @(posedge CLK) disable iff (RESET)
    cap_blk_reg[1] && !wr_en ##1 1'b1 |-> $stable(val_reg[1]);
  endproperty
  a_cap_block: assert property (p_cap_block) else $error("capture while blocked"); // RL19

  property p_ch1_off;
    @(posedge CLK) disable iff (RESET)
    buf_on |=> !CH_PIN_OE[1] && $stable(ctl_reg[1]);
  endproperty
  a_ch1_off: assert property (p_ch1_off) else $error("channel one active when linked"); // RL10

endmodule : tcc_top

`default_nettype wire

//--- verif/tcc_pin_model.sv
// Pin-side partner: channel pin drivers and external timer clock
`default_nettype none

module tcc_pin_model
(
  input  wire logic       clk,
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe,
  input  wire logic [1:0] drive,
  input  wire logic       start,
  input  wire logic [7:0] count,
  output logic      [1:0] pin_in,
  output logic            ext_clk,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] left_reg  = 8'h00;
  logic [2:0] phase_reg = 3'h0;

  // A driving channel wins the wire, else the outside source
  assign pin_in  = (pin_oe & pin_out) | (~pin_oe & drive);
  assign busy    = (left_reg != 8'h00);
  // Clock stays low between bursts, no free-running edges
  assign ext_clk = busy & phase_reg[2];

  always @(posedge clk)
  begin
    if (start)
      left_reg <= count;
    else if (busy)
    begin
      phase_reg <= phase_reg + 3'h1;
      if (phase_reg == 3'h7)
        left_reg <= left_reg - 8'h01;
    end
  end
endmodule : tcc_pin_model

`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the timer capture/compare block
`default_nettype none

module tb;
  import tcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {logic [5:0] a; logic w; logic [7:0] d; logic [7:0] e; logic [1:0] r;} tcc_row_t;

  logic              clk, reset;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, ext_clk, start, busy;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, pin_in, pin_out, pin_oe, irq, drive, r;
  logic [7:0]        count, d;
  int                bad_count, num_checks;

  tcc_row_t rows[9] = '{
    '{6'h00, 1'b0, 8'h00, 8'h20, RESP_OKAY},
    '{6'h04, 1'b0, 8'h00, 8'h00, RESP_OKAY},
    '{6'h08, 1'b0, 8'h00, 8'h00, RESP_OKAY},
    '{6'h0c, 1'b0, 8'h00, 8'hff, RESP_OKAY},
    '{6'h10, 1'b0, 8'h00, 8'hff, RESP_OKAY},
    '{6'h14, 1'b0, 8'h00, 8'h00, RESP_OKAY},
    '{6'h20, 1'b0, 8'h00, 8'h00, RESP_OKAY},
    '{6'h2c, 1'b0, 8'h00, 8'h00, RESP_ERR},
    '{6'h00, 1'b1, 8'h30, 8'h20, RESP_OKAY}};
  logic [7:0] acts[3] = '{8'h5c, 8'h58, 8'h54};
  logic [7:0] outs[3] = '{8'h01, 8'h00, 8'h01};
  logic [7:0] edg[3]  = '{8'h44, 8'h48, 8'h4c};
  logic [7:0] rise[3] = '{8'h80, 8'h00, 8'h80};
  logic [7:0] fall[3] = '{8'h00, 8'h80, 8'h80};

  tcc_top u_tcc_top (.CLK(clk), .RESET(reset), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .EXT_TIMER_CLK(ext_clk), .CH_PIN_IN(pin_in), .CH_PIN_OUT(pin_out),
    .CH_PIN_OE(pin_oe), .CHAN_IRQ(irq));

  tcc_pin_model u_tcc_pin_model (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .drive(drive), .start(start), .count(count), .pin_in(pin_in), .ext_clk(ext_clk),
    .busy(busy));

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    check("bvalid", {7'h0, bvalid}, 8'h01);
    check("bresp", {6'h0, bresp}, {6'h0, RESP_OKAY});
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [7:0] v, output logic [1:0] q);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 100);
    v = rdata[7:0];
    q = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rdc(input logic [5:0] a, input logic [7:0] e, input string nm);
    logic [7:0] v;
    logic [1:0] q;
    rd(a, v, q);
    check(nm, v, e);
  endtask : rdc

  // Burst of external timer clock pulses, then time for the synchroniser
  task automatic pulses(input logic [7:0] k);
    int n;
    n = 0;
    @(posedge clk);
    count <= k;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    while (busy === 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    repeat (4) @(posedge clk);
  endtask : pulses

  task automatic pin(input logic v);
    @(posedge clk);
    drive[1] <= v;
    repeat (6) @(posedge clk);
  endtask : pin

  task automatic run_rows();
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a, d, r);
      check("row_data", d, rows[i].e);
      check("row_resp", {6'h0, r}, {6'h0, rows[i].r});
    end
    $display("Test rows done");
  endtask : run_rows

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    repeat (50000) @(posedge clk);
    bad_count++;
    finish_test();
  end

  initial
  begin
    reset = 1'b1;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {drive, start, count} = '0;
    wstrb = 4'h1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    run_rows();
    // Software halts and clears the counter before new settings
    wr(6'h00, 8'h37);
    wr(6'h0c, 8'h00);
    wr(6'h10, 8'h08);
    wr(6'h00, 8'h07);
    pulses(8);
    rdc(6'h04, 8'h00, "cnt_hi");
    pulses(3);
    rdc(6'h04, 8'h00, "cnt_hi_again");
    rdc(6'h08, 8'h08, "cnt_lo_held");
    rdc(6'h08, 8'h02, "cnt_lo_live");
    rdc(6'h00, 8'h87, "wrap_set");
    wr(6'h00, 8'h07);
    rdc(6'h00, 8'h07, "wrap_clr");
    wr(6'h00, 8'h17);
    wr(6'h0c, 8'h00);
    pulses(10);
    rdc(6'h00, 8'h07, "wrap_held_off");
    wr(6'h10, 8'h08);
    $display("Test counter done");
    wr(6'h14, 8'h10);
    repeat (3) @(posedge clk);
    check("oe0_off", {7'h0, pin_oe[0]}, 8'h00);
    check("preset_lo", {7'h0, pin_out[0]}, 8'h00);
    wr(6'h14, 8'h00);
    repeat (3) @(posedge clk);
    check("preset_hi", {7'h0, pin_out[0]}, 8'h01);
    wr(6'h18, 8'h00);
    wr(6'h1c, 8'h04);
    foreach (acts[i])
    begin
      wr(6'h00, 8'h37);
      wr(6'h14, acts[i]);
      wr(6'h00, 8'h07);
      pulses(5);
      check("oe0_on", {7'h0, pin_oe[0]}, 8'h01);
      check("cmp_out", {7'h0, pin_out[0]}, outs[i]);
    end
    check("irq0_on", {7'h0, irq[0]}, 8'h01);
    wr(6'h14, 8'hd4);
    rdc(6'h14, 8'hd4, "flag_w1");
    wr(6'h14, 8'h54);
    rdc(6'h14, 8'h54, "flag_clr");
    check("irq0_off", {7'h0, irq[0]}, 8'h00);
    wr(6'h00, 8'h17);
    wr(6'h18, 8'h00);
    pulses(5);
    rdc(6'h14, 8'h54, "cmp_blocked");
    wr(6'h1c, 8'h04);
    wr(6'h00, 8'h37);
    wr(6'h14, 8'h1a);
    wr(6'h00, 8'h07);
    pulses(5);
    check("pwm_clr", {7'h0, pin_out[0]}, 8'h00);
    pulses(5);
    check("pwm_wrap", {7'h0, pin_out[0]}, 8'h01);
    wr(6'h14, 8'h1b);
    pulses(9);
    pulses(4);
    check("pwm_full", {7'h0, pin_out[0]}, 8'h01);
    $display("Test compare done");
    wr(6'h14, 8'h00);
    wr(6'h00, 8'h37);
    wr(6'h20, 8'h04);
    wr(6'h00, 8'h07);
    pulses(5);
    foreach (edg[i])
    begin
      wr(6'h20, edg[i]);
      rd(6'h20, d, r);
      wr(6'h20, edg[i]);
      pin(1'b1);
      rdc(6'h20, edg[i] | rise[i], "cap_rise");
      wr(6'h20, edg[i]);
      pin(1'b0);
      rdc(6'h20, edg[i] | fall[i], "cap_fall");
    end
    rdc(6'h24, 8'h00, "cap_hi");
    pulses(2);
    pin(1'b1);
    rdc(6'h28, 8'h05, "cap_held");
    pin(1'b0);
    rdc(6'h24, 8'h00, "cap_hi2");
    rdc(6'h28, 8'h07, "cap_new");
    check("irq1_on", {7'h0, irq[1]}, 8'h01);
    $display("Test capture done");
    wr(6'h20, 8'h1c);
    wr(6'h14, 8'h2c);
    repeat (3) @(posedge clk);
    check("oe1_off", {7'h0, pin_oe[1]}, 8'h00);
    check("oe0_buf", {7'h0, pin_oe[0]}, 8'h01);
    wr(6'h20, 8'h00);
    rdc(6'h20, 8'h9c, "ch1_locked");
    $display("Test buffered done");
    // Second reset in mid-run brings everything but the channel values back
    @(posedge clk);
    reset <= 1'b1;
    repeat (5) @(posedge clk);
    check("rst_oe", {6'h0, pin_oe}, 8'h00);
    check("rst_irq", {6'h0, irq}, 8'h00);
    check("rst_out", {6'h0, pin_out}, 8'h03);
    reset <= 1'b0;
    run_rows();
    finish_test();
  end
endmodule : tb

`default_nettype wire
